// [design/scss_clock_select.sv]
// Clock source selection for one serial channel, with AXI4-Lite registers.
// Assumes pins arrive asynchronous; baud and loop clocks are aclk levels.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module scss_clock_select
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        combined_clock_pin_in,
    input  wire logic        bidir_clock_pin_in,
    output logic             bidir_clock_pin_out,
    output logic             bidir_clock_pin_oe,
    output logic             sync_pin_out,
    output logic             sync_pin_oe,
    input  wire logic        xtal_osc_in,
    input  wire logic        rx_data_pin,
    // Internal clock sources
    input  wire logic        baud_rate_generator_clk,
    input  wire logic        pll_receive_output,
    input  wire logic        pll_source_clk,
    // Receiver and sync hooks
    input  wire logic        sync_pulse_req,
    input  wire logic        rx_char_done,
    // Clock and strobe outputs to receiver and transmitter, oscillator enable and status
    output logic             rx_clock,
    output logic             tx_clock,
    output logic             rx_sample,
    output logic             rx_assemble_start,
    output logic             osc_amp_enable,
    output logic             ext_sync_active,
    output logic [1:0]       encoding_effective
);

    typedef struct packed {
        logic                    aw_got;
        logic [3:0]              aw_addr;
        logic                    w_got;
        logic [7:0]              w_data;
        logic                    w_strb0;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic [7:0]              clk_mode;
        logic [6:0]              cfg;
        logic [3:0]              sync1;
        logic [3:0]              sync2;
        logic                    rx_clk;
        logic                    rx_clk_d;
        logic                    tx_clk;
        logic                    rx_sample;
        logic                    rx_data_d;
        logic                    bidir_out;
        logic                    bidir_oe;
        logic                    sync_out;
        logic                    sync_oe;
        scss_pkg::scss_rx_state_t rx_state;
        logic                    rx_start;
    } scss_state_t;

    scss_state_t st;
    scss_state_t next_st;

    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic [1:0] out_sel;
    logic       osc_en;
    logic       x1_rate;
    logic [1:0] enc_eff;
    logic       counter_clk;
    logic       combined_src;
    logic       rx_mux;
    logic       tx_mux;
    logic       out_mux;
    logic       sync_mode;

    // Selects a clock from the four documented sources
    function automatic logic pick_source(input logic [1:0] sel,
                                         input logic       comb,
                                         input logic       bidir,
                                         input logic       baud,
                                         input logic       pll);
        logic r;
        r = comb;
        if (sel == scss_pkg::SRC_BIDIR_PIN)
            r = bidir;
        else if (sel == scss_pkg::SRC_BAUD_GEN)
            r = baud;
        else if (sel == scss_pkg::SRC_PLL)
            r = pll;
        return r;
    endfunction

    assign rx_sel    = st.clk_mode[scss_pkg::CM_RX_SRC_HI:scss_pkg::CM_RX_SRC_LO];
    assign tx_sel    = st.clk_mode[scss_pkg::CM_TX_SRC_HI:scss_pkg::CM_TX_SRC_LO];
    assign out_sel   = st.clk_mode[scss_pkg::CM_BIDIR_SEL_HI:scss_pkg::CM_BIDIR_SEL_LO];
    assign osc_en    = st.clk_mode[scss_pkg::CM_OSC_EN];
    assign sync_mode = st.cfg[scss_pkg::LC_SYNC_MODE];
    assign x1_rate   = st.cfg[scss_pkg::LC_RATE_HI:scss_pkg::LC_RATE_LO] == scss_pkg::RATE_X1;

    // Oversampled rates fall back to NRZ
    assign enc_eff = x1_rate ? st.cfg[scss_pkg::LC_ENC_HI:scss_pkg::LC_ENC_LO]
                             : scss_pkg::ENC_NRZ;

    scss_tx_counter u_tx_counter
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .src_clk  (pll_source_clk),
        .div_nrzi (!enc_eff[1]),
        .tx_clk   (counter_clk)
    );

    // Combined pin path is inverted; the oscillator takes its place when on
    assign combined_src = osc_en ? st.sync2[scss_pkg::SY_XTAL]
                                 : !st.sync2[scss_pkg::SY_COMBINED];

    assign rx_mux = pick_source(rx_sel, combined_src, st.sync2[scss_pkg::SY_BIDIR],
                                baud_rate_generator_clk, pll_receive_output);
    assign tx_mux = pick_source(tx_sel, combined_src, st.sync2[scss_pkg::SY_BIDIR],
                                baud_rate_generator_clk, counter_clk);

    // Bidirectional pin output choice
    always_comb
    begin
        out_mux = st.tx_clk;
        if (out_sel == scss_pkg::OUT_XTAL_OSC)
            out_mux = osc_en ? st.sync2[scss_pkg::SY_XTAL] : 1'b1;
        else if (out_sel == scss_pkg::OUT_BAUD_GEN)
            out_mux = baud_rate_generator_clk;
        else if (out_sel == scss_pkg::OUT_PLL_RX)
            out_mux = pll_receive_output;
    end

    always_comb
    begin
        next_st = st;

        // Pin synchronisers
        next_st.sync1 = {rx_data_pin, xtal_osc_in, bidir_clock_pin_in, combined_clock_pin_in};
        next_st.sync2 = st.sync1;

        // Clock multiplexing and sample strobe on the internal falling edge
        next_st.rx_clk    = rx_mux;
        next_st.rx_clk_d  = st.rx_clk;
        next_st.tx_clk    = tx_mux;
        next_st.rx_sample = st.rx_clk_d && !st.rx_clk;
        next_st.bidir_out = out_mux;
        next_st.bidir_oe  = st.clk_mode[scss_pkg::CM_BIDIR_DRIVE]
                            && rx_sel != scss_pkg::SRC_BIDIR_PIN
                            && tx_sel != scss_pkg::SRC_BIDIR_PIN;

        // Sync pin: the amplifier owns it while enabled
        next_st.sync_oe  = !osc_en && sync_mode;
        next_st.sync_out = !osc_en && sync_mode && sync_pulse_req;

        // x1 start detection: one clock period after the first falling edge
        next_st.rx_start = 1'b0;
        if (st.rx_sample)
            next_st.rx_data_d = st.sync2[scss_pkg::SY_RX_DATA];
        if (!st.cfg[scss_pkg::LC_RX_ENABLE] || !x1_rate || sync_mode)
        begin
            next_st.rx_state = scss_pkg::RX_IDLE;
        end
        else
        begin
            case (st.rx_state)
                scss_pkg::RX_IDLE:
                begin
                    if (st.rx_sample && st.rx_data_d && !st.sync2[scss_pkg::SY_RX_DATA])
                        next_st.rx_state = scss_pkg::RX_WAIT;
                end
                scss_pkg::RX_WAIT:
                begin
                    if (st.rx_sample)
                    begin
                        next_st.rx_start = 1'b1;
                        next_st.rx_state = scss_pkg::RX_ASSEMBLE;
                    end
                end
                scss_pkg::RX_ASSEMBLE:
                begin
                    if (rx_char_done)
                        next_st.rx_state = scss_pkg::RX_IDLE;
                end
                default:
                begin
                    next_st.rx_state = scss_pkg::RX_IDLE;
                end
            endcase
        end

        // AXI write: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_got   = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_strb0 = s_axi_wstrb[0];
        end
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = scss_pkg::RESP_OKAY;
            if (st.aw_addr == scss_pkg::OFF_CLOCK_MODE)
            begin
                if (st.w_strb0)
                    next_st.clk_mode = st.w_data;
            end
            else if (st.aw_addr == scss_pkg::OFF_LINE_CONFIG)
            begin
                if (st.w_strb0)
                    next_st.cfg = st.w_data[6:0];
            end
            else if (st.aw_addr != scss_pkg::OFF_STATUS)
            begin
                next_st.bresp = scss_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        // AXI read: clock mode register is write-only and reads zero
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = scss_pkg::RESP_OKAY;
            next_st.rdata  = 32'h00000000;
            if (s_axi_araddr == scss_pkg::OFF_LINE_CONFIG)
                next_st.rdata = {25'h0000000, st.cfg};
            else if (s_axi_araddr == scss_pkg::OFF_STATUS)
                next_st.rdata = {24'h000000, st.rx_state == scss_pkg::RX_ASSEMBLE,
                                 ext_sync_active, enc_eff, st.rx_clk, st.tx_clk,
                                 osc_en, st.bidir_oe};
            else if (s_axi_araddr != scss_pkg::OFF_CLOCK_MODE)
                next_st.rresp = scss_pkg::RESP_SLVERR;
        end
        else if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st          <= '0;
            st.clk_mode <= scss_pkg::CLOCK_MODE_RESET;
            st.cfg      <= scss_pkg::LINE_CONFIG_RESET;
            st.rx_state <= scss_pkg::RX_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign s_axi_awready       = !st.aw_got && !st.bvalid;
    assign s_axi_wready        = !st.w_got && !st.bvalid;
    assign s_axi_bvalid        = st.bvalid;
    assign s_axi_bresp         = st.bresp;
    assign s_axi_arready       = !st.rvalid;
    assign s_axi_rvalid        = st.rvalid;
    assign s_axi_rdata         = st.rdata;
    assign s_axi_rresp         = st.rresp;
    assign bidir_clock_pin_out = st.bidir_out;
    assign bidir_clock_pin_oe  = st.bidir_oe;
    assign sync_pin_out        = st.sync_out;
    assign sync_pin_oe         = st.sync_oe;
    assign rx_clock            = st.rx_clk;
    assign tx_clock            = st.tx_clk;
    assign rx_sample           = st.rx_sample;
    assign rx_assemble_start   = st.rx_start;
    assign osc_amp_enable      = osc_en;
    assign ext_sync_active     = st.cfg[scss_pkg::LC_EXT_SYNC] && sync_mode && !osc_en;
    assign encoding_effective  = enc_eff;

    a_bidir_drive_cond : assert property (@(posedge aclk) disable iff (!aresetn)
        st.bidir_oe |-> ($past(st.clk_mode[scss_pkg::CM_BIDIR_DRIVE])
                         && $past(rx_sel) != scss_pkg::SRC_BIDIR_PIN
                         && $past(tx_sel) != scss_pkg::SRC_BIDIR_PIN))
        else $error("bidir pin driven while a clock uses it");

    a_osc_off_high : assert property (@(posedge aclk) disable iff (!aresetn)
        (aresetn && out_sel == scss_pkg::OUT_XTAL_OSC && !osc_en) |=> st.bidir_out)
        else $error("bidir pin not high with oscillator off");

    a_tx_from_counter : assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_sel == scss_pkg::SRC_PLL) |=> (st.tx_clk == $past(counter_clk)))
        else $error("transmit clock not taken from counter");

    a_rx_from_pll : assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_sel == scss_pkg::SRC_PLL) |=> (st.rx_clk == $past(pll_receive_output)))
        else $error("receive clock not taken from loop output");

    a_sample_on_fall : assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(st.rx_clk) |=> st.rx_sample)
        else $error("receive sample missed a falling edge");

    a_x1_wait_clock : assert property (@(posedge aclk) disable iff (!aresetn)
        st.rx_start |-> ($past(st.rx_state) == scss_pkg::RX_WAIT && $past(st.rx_sample)))
        else $error("character assembly started without one clock wait");

    a_fast_rate_nrz : assert property (@(posedge aclk) disable iff (!aresetn)
        !x1_rate |-> (encoding_effective == scss_pkg::ENC_NRZ))
        else $error("oversampled rate with non-NRZ encoding");

    a_osc_no_sync : assert property (@(posedge aclk) disable iff (!aresetn)
        osc_en ##1 osc_en |-> (!sync_pin_out && !sync_pin_oe && !ext_sync_active))
        else $error("sync pin active with oscillator enabled");

    a_osc_combined : assert property (@(posedge aclk) disable iff (!aresetn)
        (osc_en && rx_sel == scss_pkg::SRC_COMBINED_PIN)
            |=> (st.rx_clk == $past(st.sync2[scss_pkg::SY_XTAL])))
        else $error("combined pin user not fed by oscillator");

endmodule

// [design/scss_pkg.sv]
// Constants and types shared by the serial clock source select block.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
package scss_pkg;

    // AXI4-Lite address width and register byte offsets
    localparam int          ADDR_W           = 4;
    localparam logic [3:0]  OFF_CLOCK_MODE   = 4'h0;
    localparam logic [3:0]  OFF_LINE_CONFIG  = 4'h4;
    localparam logic [3:0]  OFF_STATUS       = 4'h8;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Values after reset
    localparam logic [7:0]  CLOCK_MODE_RESET = 8'h08;
    localparam logic [6:0]  LINE_CONFIG_RESET = 7'h00;

    // Clock mode register fields
    localparam int          CM_OSC_EN        = 7;
    localparam int          CM_RX_SRC_HI     = 6;
    localparam int          CM_RX_SRC_LO     = 5;
    localparam int          CM_TX_SRC_HI     = 4;
    localparam int          CM_TX_SRC_LO     = 3;
    localparam int          CM_BIDIR_DRIVE   = 2;
    localparam int          CM_BIDIR_SEL_HI  = 1;
    localparam int          CM_BIDIR_SEL_LO  = 0;

    // Clock source codes for the receive and transmit fields
    localparam logic [1:0]  SRC_COMBINED_PIN = 2'h0;
    localparam logic [1:0]  SRC_BIDIR_PIN    = 2'h1;
    localparam logic [1:0]  SRC_BAUD_GEN     = 2'h2;
    localparam logic [1:0]  SRC_PLL          = 2'h3;

    // Bidirectional pin output selection codes
    localparam logic [1:0]  OUT_XTAL_OSC     = 2'h0;
    localparam logic [1:0]  OUT_TX_CLOCK     = 2'h1;
    localparam logic [1:0]  OUT_BAUD_GEN     = 2'h2;
    localparam logic [1:0]  OUT_PLL_RX       = 2'h3;

    // Line configuration register fields
    localparam int          LC_ENC_HI        = 1;
    localparam int          LC_ENC_LO        = 0;
    localparam int          LC_RATE_HI       = 3;
    localparam int          LC_RATE_LO       = 2;
    localparam int          LC_SYNC_MODE     = 4;
    localparam int          LC_EXT_SYNC      = 5;
    localparam int          LC_RX_ENABLE     = 6;

    // Data encodings and asynchronous clock rates
    localparam logic [1:0]  ENC_NRZ          = 2'h0;
    localparam logic [1:0]  ENC_NRZI         = 2'h1;
    localparam logic [1:0]  ENC_FM1          = 2'h2;
    localparam logic [1:0]  ENC_FM0          = 2'h3;
    localparam logic [1:0]  RATE_X1          = 2'h0;

    // Transmit clock counter divide ratios
    localparam int          FM_DIVIDE        = 16;
    localparam int          NRZI_DIVIDE      = 32;

    // Synchroniser bit positions
    localparam int          SY_COMBINED      = 0;
    localparam int          SY_BIDIR         = 1;
    localparam int          SY_XTAL          = 2;
    localparam int          SY_RX_DATA       = 3;

    typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_ASSEMBLE} scss_rx_state_t;

endpackage

// [design/scss_tx_counter.sv]
// Transmit clock counter running beside the phase-locked loop.
// Assumes src_clk is a level from logic on aclk, sampled every cycle.
`timescale 1ns/1ps
module scss_tx_counter
#(
    parameter int FM_DIV   = scss_pkg::FM_DIVIDE,
    parameter int NRZI_DIV = scss_pkg::NRZI_DIVIDE
)
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Source clock level and ratio select
    input  wire logic src_clk,
    input  wire logic div_nrzi,
    // Divided transmit clock
    output logic      tx_clk
);

    typedef struct packed {
        logic       src_d;
        logic [4:0] count;
        logic       out;
    } scss_cnt_t;

    scss_cnt_t st;
    scss_cnt_t next_st;
    logic [4:0] half_last;
    logic       src_rise;

    // Half period in source edges, less one
    assign half_last = div_nrzi ? 5'(NRZI_DIV / 2 - 1) : 5'(FM_DIV / 2 - 1);
    assign src_rise  = src_clk && !st.src_d;

    always_comb
    begin
        next_st       = st;
        next_st.src_d = src_clk;
        if (src_rise)
        begin
            if (st.count >= half_last)
            begin
                next_st.count = 5'h00;
                next_st.out   = !st.out;
            end
            else
            begin
                next_st.count = st.count + 5'h01;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign tx_clk = st.out;

    a_toggle_on_wrap : assert property (@(posedge aclk) disable iff (!aresetn)
        (st.out != $past(st.out)) |-> ($past(src_rise) && $past(st.count) == $past(half_last)))
        else $error("transmit counter toggled off its wrap");

endmodule

// [dv/scss_modem_model.sv]
// Modem and crystal on the clock pins of one channel.
// Assumes the bench sets line levels; the device owns the bidir pin while its oe is high.
`timescale 1ns/1ps
module scss_modem_model
(
    // Bench levels
    input  wire logic lvl_comb,
    input  wire logic lvl_bidir,
    // Device side
    input  wire logic osc_amp_enable,
    input  wire logic bidir_out,
    input  wire logic bidir_oe,
    // Pins
    output logic      comb_pin,
    output logic      bidir_pin,
    output logic      xtal
);
    // Crystal shows activity only while the amplifier runs
    assign xtal      = osc_amp_enable & lvl_comb;
    assign comb_pin  = lvl_comb;
    assign bidir_pin = bidir_oe ? bidir_out : lvl_bidir;
endmodule

// [dv/testbench.sv]
// Self-checking bench for the serial clock source select block.
// Assumes the modem model on the pins and an AXI4-Lite master inside the bench.
`timescale 1ns/1ps
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, encoding_effective;
    logic        combined_clock_pin_in, bidir_clock_pin_in, bidir_clock_pin_out;
    logic        bidir_clock_pin_oe, sync_pin_out, sync_pin_oe, xtal_osc_in;
    logic        rx_data_pin = 1'b1, baud_rate_generator_clk = 1'b0;
    logic        pll_receive_output = 1'b0, pll_source_clk = 1'b0;
    logic        sync_pulse_req = 1'b0, rx_char_done = 1'b0;
    logic        rx_clock, tx_clock, rx_sample, rx_assemble_start;
    logic        osc_amp_enable, ext_sync_active;
    logic        lvl_comb = 1'b0, lvl_bidir = 1'b0;
    logic [9:0]  bt [5] = '{10'h304, 10'h00C, 10'h024, 10'h106, 10'h307};
    int          bad_count = 0, cmp_count = 0;

    always #5 aclk = ~aclk;

    scss_clock_select dut (.*);
    scss_modem_model modem
    (
        .lvl_comb(lvl_comb), .lvl_bidir(lvl_bidir), .osc_amp_enable(osc_amp_enable),
        .bidir_out(bidir_clock_pin_out), .bidir_oe(bidir_clock_pin_oe),
        .comb_pin(combined_clock_pin_in), .bidir_pin(bidir_clock_pin_in), .xtal(xtal_osc_in)
    );

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                chk("bresp", 32'(scss_pkg::RESP_OKAY), 32'(s_axi_bresp));
                break;
            end
        end
    endtask

    task automatic axr(input logic [3:0] a, input logic [1:0] er, input logic [7:0] ed);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                chk("rresp", 32'(er), 32'(s_axi_rresp));
                chk("rdata", {24'h0, ed}, s_axi_rdata);
                break;
            end
        end
    endtask

    // Selection is written while clocks are steady, then the sync lag settles
    task automatic cm(input logic [7:0] d);
        axw(scss_pkg::OFF_CLOCK_MODE, d);
        repeat (6) @(posedge aclk);
    endtask

    // 128 source rises, counting edges of the divided clock and of the pin meanwhile
    task automatic div(input int exp_n);
        int   n;
        int   m;
        logic t;
        logic b;
        n = 0;
        m = 0;
        t = tx_clock;
        b = bidir_clock_pin_out;
        for (int i = 0; i < 262; i++)
        begin
            @(posedge aclk);
            pll_source_clk <= (i < 256) ? ~pll_source_clk : 1'b0;
            if (tx_clock !== t) n++;
            if (bidir_clock_pin_out !== b) m++;
            t = tx_clock;
            b = bidir_clock_pin_out;
        end
        chk("tx divide", 32'(exp_n), 32'(n));
        chk("pin divide", 32'(exp_n), 32'(m));
    endtask

    // Baud clock serves as receive clock for 20 periods; the line falls once
    task automatic x1_rx;
        int ns;
        int nst;
        ns = 0;
        nst = 0;
        for (int i = 0; i < 44; i++)
        begin
            @(posedge aclk);
            if (i < 40) baud_rate_generator_clk <= ~baud_rate_generator_clk;
            if (i == 10) rx_data_pin <= 1'b0;
            if (rx_sample === 1'b1) ns++;
            if (rx_assemble_start === 1'b1) nst++;
        end
        chk("rx samples", 32'h14, 32'(ns));
        chk("x1 start", 32'h1, 32'(nst));
    endtask

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk("oe reset", 32'h0, 32'(bidir_clock_pin_oe));
        chk("osc reset", 32'h0, 32'(osc_amp_enable));
        axr(scss_pkg::OFF_LINE_CONFIG, scss_pkg::RESP_OKAY, 8'h00);
        axr(scss_pkg::OFF_CLOCK_MODE, scss_pkg::RESP_OKAY, 8'h00);
        axr(4'hC, scss_pkg::RESP_SLVERR, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                lvl_comb <= p[0];
                lvl_bidir <= p[0];
                pll_receive_output <= p[0];
                baud_rate_generator_clk <= ~p[0];
                cm({1'b0, c[1:0], c[1:0], 3'h0});
                chk("rx clock", 32'((c % 2 == 1) ? p : 1 - p), 32'(rx_clock));
                if (c < 3) chk("tx clock", 32'((c % 2 == 1) ? p : 1 - p), 32'(tx_clock));
            end
        end
        foreach (bt[i])
        begin
            cm(bt[i][7:0]);
            chk("pin oe", 32'(bt[i][8]), 32'(bidir_clock_pin_oe));
            if (bt[i][8]) chk("pin out", 32'(bt[i][9]), 32'(bidir_clock_pin_out));
        end
        cm(8'h84);
        chk("osc on", 32'h1, 32'(osc_amp_enable));
        chk("xtal out", 32'h1, 32'(bidir_clock_pin_out));
        chk("rx xtal", 32'h1, 32'(rx_clock));
        sync_pulse_req <= 1'b1;
        axw(scss_pkg::OFF_LINE_CONFIG, 8'h30);
        axr(scss_pkg::OFF_LINE_CONFIG, scss_pkg::RESP_OKAY, 8'h30);
        chk("ext sync osc", 32'h0, 32'(ext_sync_active));
        chk("sync pin osc", 32'h0, 32'({sync_pin_oe, sync_pin_out}));
        cm(8'h00);
        chk("ext sync", 32'h1, 32'(ext_sync_active));
        chk("sync pin", 32'h3, 32'({sync_pin_oe, sync_pin_out}));
        axw(scss_pkg::OFF_LINE_CONFIG, 8'h05);
        repeat (2) @(posedge aclk);
        chk("enc fast", 32'(scss_pkg::ENC_NRZ), 32'(encoding_effective));
        axw(scss_pkg::OFF_LINE_CONFIG, 8'h01);
        repeat (2) @(posedge aclk);
        chk("enc x1", 32'(scss_pkg::ENC_NRZI), 32'(encoding_effective));
        cm(8'h1D);
        div(8);
        axw(scss_pkg::OFF_LINE_CONFIG, 8'h03);
        div(16);
        cm(8'h7F);
        chk("rx loop", 32'(pll_receive_output), 32'(rx_clock));
        chk("pin loop rx", 32'(pll_receive_output), 32'(bidir_clock_pin_out));
        cm(8'h40);
        axw(scss_pkg::OFF_LINE_CONFIG, 8'h40);
        x1_rx();
        axr(scss_pkg::OFF_STATUS, scss_pkg::RESP_OKAY, 8'h80);
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report();
    end
endmodule
